// ---- ubrk_pkg.sv ----
/*
  ubrk_pkg: constants and carrier types for the break-capable serial transmitter/receiver.
  Assumes a single system clock domain; consumers import ubrk_pkg::*.
*/
package ubrk_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned DEF_BAUD_DIV    = 16'd87;   // cycles per bit, default setting
  localparam int unsigned BREAK_ZEROS     = 12;
  localparam int unsigned DATA_BITS       = 8;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned WAKE_EDGES      = 2;
  localparam logic [3:0]  TX_CNT_ZERO     = 4'h0;
  localparam logic [15:0] DIV_ZERO        = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  typedef struct packed {
    logic       transmit_enable;      // transmitter on
    logic       send_break_request;   // next frame is a break
    logic [15:0] baud_div;            // cycles per bit, minus one
  } ubrk_ctrl_type;

  typedef struct packed {
    logic       shift_register_empty;  // no frame shifting
    logic       tx_buffer_empty_flag;  // holding buffer holds no byte
    logic       rx_data_flag;          // received byte or wake event pending
    logic [7:0] rx_data;               // last received byte
  } ubrk_stat_type;
endpackage : ubrk_pkg

// ---- ubrk_fifo.sv ----
/*
  ubrk_fifo: parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module ubrk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,     // system clock
  input  wire logic             sys_rst,   // async reset, active high
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // space available
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // data available
  input  wire logic             out_ready, // read request
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                     (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : ubrk_fifo

// ---- ubrk_core.sv ----
/*
  ubrk_core: asynchronous serial transmitter with break-frame generation and a receiver
  with auto-wake-up on break. Control and status are plain ports, no register bus.
  Assumes serial_receive_pin is asynchronous (synchronised here) and that the bit
  period is set by the caller through ctrl.baud_div.
*/
// Overview of operation
// [R01] A break frame is a start bit, twelve zero bits and a stop bit on the tx line.
// [R02] A break frame goes out when send-break and transmit-enable are set and a byte is loaded.
// [R03] The byte that launches a break is ignored and only zeros are shifted.
// [R04] Send-break clears itself by hardware once the break's stop bit has gone out.
// [R05] The buffer accepts the next byte during a break so it follows the break directly.
// [R06] Shift-register-empty shows busy while a break shifts and idle after, as for data.
// [R07] Software sets mode, enable and send-break, writes a dummy byte, then writes 55h.
// [R08] After the break the queued sync byte goes out as a normal frame.
// [R09] The buffer-empty flag rises when the buffer empties; software waits for it.
// [R10] Software may receive a break by running the receiver at 9/13 of the bit rate.
// [R11] With auto-wake-up the receiver sees two edges, flags, then receives a byte and flags.
// [R12] Software is advised to enable auto-baud after a break once buffer-empty is seen.
// [R13] Each break bit lasts one bit period of the configured rate, same as data bits.
`timescale 1ns/100ps
module ubrk_core
  import ubrk_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic                    clock,              // system clock, 10 MHz
  input  wire logic                    sys_rst,            // async reset, active high
  input  wire ubrk_pkg::ubrk_ctrl_type ctrl,               // enable, break request, divider
  input  wire logic                    send_break_set,     // pulse: request a break
  input  wire logic                    holding_wr,         // write to holding register
  input  wire logic [7:0]              holding_data,       // byte written
  output logic                         holding_ready,      // buffer can accept a write
  input  wire logic                    auto_wake_enable,   // wake on break edges
  input  wire logic                    rx_flag_clear,      // pulse: software read of rx data
  input  wire logic                    serial_receive_pin, // rx line, asynchronous
  output logic                         serial_transmit,    // tx line
  output logic                         send_break_request, // current break request bit
  output ubrk_pkg::ubrk_stat_type      stat                // status bits
);
  import ubrk_pkg::*;
  initial begin
    if (FIFO_DEPTH_P < 2) $error("fifo depth too small");
  end

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} ubrk_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_WAKE, RX_BITS, RX_STOP} ubrk_rx_state_type;

  function automatic logic div_done(input logic [15:0] cnt);
    div_done = cnt == DIV_ZERO;
  endfunction : div_done

  // transmit side
  logic              fifo_valid;
  logic [7:0]        fifo_data;
  logic              fifo_pop;
  ubrk_tx_state_type tx_state_reg;
  logic [15:0]       tx_div_reg;
  logic [3:0]        tx_cnt_reg;
  logic [7:0]        tx_shift_reg;
  logic              tx_is_break_reg;
  logic              break_req_reg;
  logic              tx_line_reg;

  ubrk_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (holding_wr),
    .in_ready  (holding_ready),
    .in_data   (holding_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // loading only when idle lets the next byte wait in the buffer during a break
  assign fifo_pop = (tx_state_reg == TX_IDLE) & fifo_valid & ctrl.transmit_enable; // [R02] [R05]

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state_reg    <= TX_IDLE;
      tx_div_reg      <= DIV_ZERO;
      tx_cnt_reg      <= TX_CNT_ZERO;
      tx_shift_reg    <= BYTE_ZERO;
      tx_is_break_reg <= 1'b0;
      tx_line_reg     <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (fifo_pop) begin
            tx_is_break_reg <= break_req_reg;                                 // [R02]
            tx_shift_reg    <= break_req_reg ? BYTE_ZERO : fifo_data;         // [R03]
            tx_div_reg      <= ctrl.baud_div;                                 // [R13]
            tx_line_reg     <= 1'b0;
            tx_state_reg    <= TX_START;
          end
        end
        TX_START: begin
          if (div_done(tx_div_reg)) begin
            tx_div_reg   <= ctrl.baud_div;
            tx_cnt_reg   <= TX_CNT_ZERO;
            tx_line_reg  <= tx_is_break_reg ? 1'b0 : tx_shift_reg[0];        // [R01] [R03]
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_state_reg <= TX_BITS;
          end else tx_div_reg <= tx_div_reg - 1'b1;
        end
        TX_BITS: begin
          if (div_done(tx_div_reg)) begin
            tx_div_reg <= ctrl.baud_div;                                       // [R13]
            if (tx_cnt_reg == (tx_is_break_reg ? 4'(BREAK_ZEROS - 1)
                                               : 4'(DATA_BITS - 1))) begin    // [R01]
              tx_line_reg  <= 1'b1;
              tx_state_reg <= TX_STOP;
            end else begin
              tx_cnt_reg   <= tx_cnt_reg + 1'b1;
              tx_line_reg  <= tx_is_break_reg ? 1'b0 : tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
          end else tx_div_reg <= tx_div_reg - 1'b1;
        end
        TX_STOP: begin
          if (div_done(tx_div_reg)) begin
            tx_is_break_reg <= 1'b0;
            tx_state_reg    <= TX_IDLE;                                        // [R08]
          end else tx_div_reg <= tx_div_reg - 1'b1;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  logic break_done;
  assign break_done = (tx_state_reg == TX_STOP) & tx_is_break_reg & div_done(tx_div_reg);

  // ctrl level sets the request but never clears it; the set pulse wins over the hardware clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      break_req_reg <= 1'b0;
    end else if (send_break_set) begin
      break_req_reg <= 1'b1;
    end else if (break_done) begin
      break_req_reg <= 1'b0;                                                   // [R04]
    end else if (ctrl.send_break_request) begin
      break_req_reg <= 1'b1;
    end
  end

  assign serial_transmit    = tx_line_reg;
  assign send_break_request = break_req_reg;

  // receive side
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              rx_prev_reg;
  ubrk_rx_state_type rx_state_reg;
  logic [15:0]       rx_div_reg;
  logic [3:0]        rx_cnt_reg;
  logic [7:0]        rx_shift_reg;
  logic [7:0]        rx_data_reg;
  logic [1:0]        wake_edges_reg;
  logic              wake_spent_reg;
  logic              rx_event_reg;
  logic              rx_flag_reg;
  logic              rx_fall;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_receive_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_fall = rx_prev_reg & ~rx_sync_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state_reg   <= RX_IDLE;
      rx_div_reg     <= DIV_ZERO;
      rx_cnt_reg     <= TX_CNT_ZERO;
      rx_shift_reg   <= BYTE_ZERO;
      rx_data_reg    <= BYTE_ZERO;
      wake_edges_reg <= 2'h0;
      wake_spent_reg <= 1'b0;
      rx_event_reg   <= 1'b0;
    end else begin
      rx_event_reg <= 1'b0;
      // a wake is spent once used, so the byte behind the break is received normally
      if (!auto_wake_enable) wake_spent_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_fall) begin
            if (auto_wake_enable && !wake_spent_reg) begin
              wake_edges_reg <= 2'h1;
              rx_state_reg   <= RX_WAKE;                                       // [R11]
            end else begin
              rx_div_reg   <= {1'b0, ctrl.baud_div[15:1]};  // sample mid start bit
              rx_cnt_reg   <= TX_CNT_ZERO;
              rx_state_reg <= RX_BITS;
            end
          end
        end
        RX_WAKE: begin
          // break fall then rise: two edges, then flag and return to data reception
          if (rx_prev_reg != rx_sync_reg) begin
            if (wake_edges_reg == 2'(WAKE_EDGES - 1)) begin
              rx_event_reg   <= 1'b1;                                          // [R11]
              wake_spent_reg <= 1'b1;
              rx_state_reg   <= RX_IDLE;
            end else wake_edges_reg <= wake_edges_reg + 1'b1;
          end
        end
        RX_BITS: begin
          if (div_done(rx_div_reg)) begin
            rx_div_reg <= ctrl.baud_div;
            if (rx_cnt_reg != TX_CNT_ZERO) rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
            if (rx_cnt_reg == 4'(DATA_BITS)) rx_state_reg <= RX_STOP;
            else rx_cnt_reg <= rx_cnt_reg + 1'b1;
          end else rx_div_reg <= rx_div_reg - 1'b1;
        end
        RX_STOP: begin
          if (div_done(rx_div_reg)) begin
            rx_data_reg  <= rx_shift_reg;
            rx_event_reg <= 1'b1;                                              // [R11]
            rx_state_reg <= RX_IDLE;
          end else rx_div_reg <= rx_div_reg - 1'b1;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) rx_flag_reg <= 1'b0;
    else if (rx_event_reg) rx_flag_reg <= 1'b1;
    else if (rx_flag_clear) rx_flag_reg <= 1'b0;
  end

  always_comb begin
    stat.shift_register_empty = tx_state_reg == TX_IDLE;                       // [R06]
    stat.tx_buffer_empty_flag = ~fifo_valid;                                    // [R09]
    stat.rx_data_flag         = rx_flag_reg;
    stat.rx_data              = rx_data_reg;
  end
endmodule : ubrk_core

// ---- ubrk_core_chk.sv ----
/*
  ubrk_core_chk: concurrent checks on the ports of ubrk_core.
  Assumes it is bound to ubrk_core; one clock, asynchronous active-high reset.
*/
`timescale 1ns/100ps
module ubrk_core_chk
  import ubrk_pkg::*;
(
  input wire logic                    clock,              // system clock
  input wire logic                    sys_rst,            // async reset
  input wire ubrk_pkg::ubrk_ctrl_type ctrl,               // control bits
  input wire logic                    send_break_set,     // break pulse
  input wire logic                    holding_wr,         // buffer write
  input wire logic                    holding_ready,      // buffer space
  input wire logic                    serial_transmit,    // tx line
  input wire logic                    send_break_request, // break bit
  input wire ubrk_pkg::ubrk_stat_type stat                // status
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // cycles the tx line has been low, to time the break run
  logic [19:0] low_cnt;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) low_cnt <= 20'h0;
    else if (serial_transmit) low_cnt <= 20'h0;
    else low_cnt <= low_cnt + 20'h1;
  end

  sequence s_write;
    holding_wr && holding_ready;
  endsequence
  sequence s_break_end;
    $fell(send_break_request);
  endsequence

  a_idle_high: assert property (stat.shift_register_empty |-> serial_transmit)
    else $error("tx line low while idle");
  a_break_len: assert property ($rose(serial_transmit)
    && low_cnt > 9 * (ctrl.baud_div + 1)
    |-> low_cnt == 13 * (ctrl.baud_div + 1))
    else $error("break low run has wrong length");
  a_write_fills: assert property (s_write |=> !stat.tx_buffer_empty_flag)
    else $error("buffer empty flag after accepted write");
  a_empty_ready: assert property (stat.tx_buffer_empty_flag |-> holding_ready)
    else $error("empty buffer refuses a byte");
  a_pulse_sets: assert property (send_break_set |=> send_break_request)
    else $error("break pulse did not set request");
  // the hardware clear at the end of a break outranks the level
  a_level_sets: assert property (ctrl.send_break_request
    |=> send_break_request || $fell(send_break_request))
    else $error("break level did not set request");
  a_clear_high: assert property (s_break_end |-> serial_transmit)
    else $error("break request cleared before stop bit");
  a_no_load_off: assert property ($past(!ctrl.transmit_enable)
    && $past(stat.shift_register_empty) |-> stat.shift_register_empty)
    else $error("frame started with transmitter off");
endmodule : ubrk_core_chk

// ---- ubrk_node.sv ----
/*
  ubrk_node: far serial node driving the receive line of the block.
  Assumes the caller is at a falling clock edge; line idles high (pulled up).
*/
`timescale 1ns/100ps
module ubrk_node (
  input  wire logic clock, // system clock
  output logic      line   // serial line toward the block
);
  initial line = 1'h1;

  // brk sends start, twelve zeros and stop
  task automatic send(input logic [7:0] d, input bit brk, input int cyc);
    logic [13:0] f;
    int          n;
    n = brk ? 14 : 10;
    f = brk ? 14'h2000 : {5'h1f, d, 1'h0};
    for (int i = 0; i < n; i++) begin
      line = f[i];
      repeat (cyc) @(negedge clock);
    end
  endtask : send
endmodule : ubrk_node

// ---- tb_uart_break_char_handling.sv ----
/*
  tb_uart_break_char_handling: self-checking bench for ubrk_core.
  Assumes the package, design, node model and checker are compiled first.
*/
`timescale 1ns/100ps
module tb_uart_break_char_handling;
  import ubrk_pkg::*;
  localparam int BIT = 4;
  logic          clock, sys_rst, send_break_set, holding_wr, holding_ready;
  logic          auto_wake_enable, rx_flag_clear, rx_line, serial_transmit;
  logic          send_break_request;
  logic [7:0]    holding_data;
  logic [13:0]   v;
  ubrk_ctrl_type ctrl;
  ubrk_stat_type stat;
  int            fail_count, n_tests;

  ubrk_core #(.FIFO_DEPTH_P(16)) dut_u (.clock(clock), .sys_rst(sys_rst), .ctrl(ctrl),
    .send_break_set(send_break_set), .holding_wr(holding_wr), .holding_data(holding_data),
    .holding_ready(holding_ready), .auto_wake_enable(auto_wake_enable),
    .rx_flag_clear(rx_flag_clear), .serial_receive_pin(rx_line),
    .serial_transmit(serial_transmit), .send_break_request(send_break_request), .stat(stat));
  ubrk_node node_u (.clock(clock), .line(rx_line));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk

  // samples nb bits of the next tx frame at mid bit, returns at the last sample
  task automatic grab(input int nb);
    int k;
    k = 0;
    v = '1;
    while (serial_transmit !== 1'h0) begin
      @(negedge clock);
      k++;
      if (k > 3000) begin
        chk(1'h0, "no frame on tx");
        tally_and_finish();
      end
    end
    repeat (BIT / 2) @(negedge clock);
    for (int i = 0; i < nb; i++) begin
      if (i > 0) repeat (BIT) @(negedge clock);
      v[i] = serial_transmit;
      if (i == 1) chk(stat.shift_register_empty === 1'h0, "idle flag during frame");
    end
  endtask : grab

  // bounded wait for the buffer-empty flag before the next write
  task automatic wait_empty;
    int k;
    k = 0;
    while (stat.tx_buffer_empty_flag !== 1'h1) begin
      @(negedge clock);
      k++;
      if (k > 3000) begin
        chk(1'h0, "buffer never emptied");
        tally_and_finish();
      end
    end
  endtask : wait_empty

  task automatic t_header;
    ctrl.transmit_enable = 1'h1;
    send_break_set = 1'h1;
    @(negedge clock);
    send_break_set = 1'h0;
    chk(send_break_request === 1'h1, "break request not set");
    holding_wr = 1'h1;
    holding_data = 8'ha5;
    @(negedge clock);
    holding_wr = 1'h0;
    chk(stat.tx_buffer_empty_flag === 1'h0, "dummy byte not taken");
    wait_empty();
    holding_wr = 1'h1;
    holding_data = 8'h55;
    chk(holding_ready === 1'h1, "sync byte refused during break");
    @(negedge clock);
    holding_wr = 1'h0;
    chk(stat.tx_buffer_empty_flag === 1'h0, "sync byte not queued");
    grab(14);
    chk(v === 14'h2000, "break frame shape");
    repeat (3) @(negedge clock);
    chk(send_break_request === 1'h0, "break request not cleared");
    grab(10);
    chk(v[9:0] === {1'h1, 8'h55, 1'h0}, "sync byte after break");
    repeat (BIT) @(negedge clock);
    chk(stat.shift_register_empty === 1'h1, "not idle after sync");
    chk(stat.tx_buffer_empty_flag === 1'h1, "buffer not empty");
  endtask : t_header

  // transmitter off stalls the drain; seventeenth write must be dropped
  task automatic t_fill;
    ctrl.transmit_enable = 1'h0;
    ctrl.send_break_request = 1'h1;
    @(negedge clock);
    ctrl.send_break_request = 1'h0;
    chk(send_break_request === 1'h1, "level did not set break");
    holding_wr = 1'h1;
    for (int i = 0; i < 17; i++) begin
      holding_data = (i < 16) ? 8'(i * 17 + 3) : 8'hee;
      chk(holding_ready === (i < 16), "buffer ready wrong while filling");
      @(negedge clock);
    end
    holding_wr = 1'h0;
    chk(stat.shift_register_empty === 1'h1, "frame started while disabled");
    ctrl.transmit_enable = 1'h1;
    grab(14);
    chk(v === 14'h2000, "first byte not replaced by break");
    for (int i = 1; i < 16; i++) begin
      grab(10);
      chk(v[9:0] === {1'h1, 8'(i * 17 + 3), 1'h0}, "drained byte");
    end
    repeat (4 * BIT) @(negedge clock);
    chk(serial_transmit === 1'h1 && stat.tx_buffer_empty_flag === 1'h1, "extra frame");
    chk(stat.shift_register_empty === 1'h1, "dropped byte was sent");
  endtask : t_fill

  task automatic rx_expect(input logic [7:0] d, input logic dchk);
    repeat (4) @(negedge clock);
    chk(stat.rx_data_flag === 1'h1 && (!dchk || stat.rx_data === d), "rx flag or data");
    rx_flag_clear = 1'h1;
    @(negedge clock);
    rx_flag_clear = 1'h0;
    @(negedge clock);
    chk(stat.rx_data_flag === 1'h0, "rx flag not cleared");
  endtask : rx_expect

  task automatic t_rx;
    node_u.send(8'h3c, 1'h0, BIT);
    rx_expect(8'h3c, 1'h1);
    auto_wake_enable = 1'h1;
    node_u.send(8'h00, 1'h1, BIT);
    rx_expect(8'h00, 1'h0);
    // enable stays high: the byte behind the wake must still be received
    node_u.send(8'h55, 1'h0, BIT);
    rx_expect(8'h55, 1'h1);
    auto_wake_enable = 1'h0;
  endtask : t_rx

  // receiver slowed to 9/13 of the sender's rate sees a break as a zero byte
  task automatic t_rx_slow;
    ctrl.baud_div = 16'h000c;
    node_u.send(8'h00, 1'h1, 9);
    rx_expect(8'h00, 1'h1);
    ctrl.baud_div = 16'h0003;
  endtask : t_rx_slow

  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  initial begin
    sys_rst = 1'h1;
    ctrl = '0;
    ctrl.baud_div = 16'h0003;
    {send_break_set, holding_wr, auto_wake_enable, rx_flag_clear} = 4'h0;
    holding_data = 8'h00;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(negedge clock);
    sys_rst = 1'h0;
    @(negedge clock);
    chk(serial_transmit === 1'h1 && send_break_request === 1'h0, "reset tx state");
    chk(stat.shift_register_empty === 1'h1 && holding_ready === 1'h1, "reset status");
    t_header();
    t_fill();
    t_rx();
    t_rx_slow();
    tally_and_finish();
  end
endmodule : tb_uart_break_char_handling

bind ubrk_core ubrk_core_chk chk_u (.clock(clock), .sys_rst(sys_rst), .ctrl(ctrl),
  .send_break_set(send_break_set), .holding_wr(holding_wr), .holding_ready(holding_ready),
  .serial_transmit(serial_transmit), .send_break_request(send_break_request), .stat(stat));
